/* File: eal_top.sv */
// Equalizer adaptation and lock control of one channel
`timescale 1ns/1ns
`include "eal_params.svh"
module eal_top (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    output logic [7:0]             reg_rdata,
    // Clock recovery
    output logic                   cdr_acquire,
    output logic [3:0]             cdr_rate_code,
    output logic [3:0]             coarse_vco_sel,
    input  wire logic              cdr_phase_locked,
    // Equalizer
    output logic [4:0]             eq_boost_idx,
    // Eye scanner
    output logic                   eye_meas_req,
    input  wire logic              eye_meas_done,
    input  wire eal_pkg::eal_eye_t eye_meas,
    // Reference comparison ticks
    input  wire logic              ref_tick,
    input  wire logic              vco_tick,
    // Status
    output logic                   lock_status,
    output logic                   adapt_busy,
    output logic                   lol_irq
);
    import eal_pkg::*;

    logic [7:0]   reg_boost;
    logic [7:0]   reg_look;
    logic [7:0]   reg_rate;
    logic [7:0]   reg_mode;
    logic [7:0]   reg_refmode;
    logic [7:0]   reg_mon;
    logic [7:0]   reg_thr;
    logic [7:0]   reg_wa;
    logic [7:0]   reg_ob;
    logic [7:0]   reg_oc;
    logic [7:0]   reg_fomen;
    logic [7:0]   next_rdata;

    eal_state_t   state;
    logic [4:0]   cur_idx;
    logic [4:0]   best_idx;
    logic [9:0]   best_score;
    logic [9:0]   cur_score;
    logic [3:0]   beyond;
    logic [12:0]  timer;
    logic         mon_pend;
    logic         boost_wr_hw;
    logic         start_prev;
    logic         start_evt;

    eal_fom_cfg_t fom_cfg;
    logic [9:0]   score;
    logic         adapt_on;
    logic [7:0]   heo_min;
    logic [7:0]   veo_min;
    logic         eye_ok;
    logic         eye_low;
    logic         cal_done;
    logic         drift_evt;
    logic         spur_evt;
    logic         unlock;

    assign fom_cfg = '{fom_type:  reg_mode[`EAL_TYPE_HI:`EAL_TYPE_LO],
                       custom_en: reg_fomen[`EAL_FOM_EN_BIT],
                       a: reg_wa, b: reg_ob, c: reg_oc};       // see R5
    // Codes 00, 10 and 11 all leave the equalizer to the user
    assign adapt_on = (reg_mode[`EAL_MODE_HI:`EAL_MODE_LO]
                       == `EAL_MODE_ADAPT);                    // see R8, R21
    assign heo_min  = {reg_thr[7:4], 4'h0};
    assign veo_min  = {reg_thr[3:0], 4'h0};
    assign eye_ok   = (eye_meas.horizontal_eye_width > heo_min) && (eye_meas.vertical_eye_height > veo_min);
    assign eye_low  = (eye_meas.horizontal_eye_width < heo_min) || (eye_meas.vertical_eye_height < veo_min);
    assign start_evt = start_prev && !reg_rate[`EAL_START_BIT];    // see R13
    assign unlock   = (state == S_LOCKED) && (!cdr_phase_locked || drift_evt
                      || spur_evt
                      || (mon_pend && eye_meas_done && eye_low));  // see R10

    eal_score u_score (
        .eye   (eye_meas),
        .cfg   (fom_cfg),
        .score (score)
    );

    eal_refmon u_refmon (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .ref_tick   (ref_tick),
        .vco_tick   (vco_tick),
        .rate_code  (cdr_rate_code),
        .locked     (lock_status),
        .coarse_sel (coarse_vco_sel),
        .cal_done   (cal_done),
        .drift_evt  (drift_evt),
        .spur_evt   (spur_evt)
    );

    // Register writes; the chosen boost from adaptation wins a collision
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_boost   <= `EAL_RST_BOOST;
            reg_look    <= `EAL_RST_LOOK;
            reg_rate    <= `EAL_RST_RATE;
            reg_mode    <= `EAL_RST_MODE;
            reg_refmode <= `EAL_RST_REFMODE;
            reg_mon     <= `EAL_RST_MON;
            reg_thr     <= `EAL_RST_THR;
            reg_wa      <= `EAL_RST_WA;
            reg_ob      <= `EAL_RST_OB;
            reg_oc      <= `EAL_RST_OC;
            reg_fomen   <= `EAL_RST_FOMEN;
        end else begin
            if (boost_wr_hw) begin
                reg_boost <= {3'h0, best_idx};                   // see R20
            end else if (reg_wr && reg_addr == `EAL_REG_BOOST) begin
                reg_boost <= reg_wdata;
            end
            if (reg_wr) begin
                if (reg_addr == `EAL_REG_LOOK) begin
                    reg_look <= reg_wdata;
                end else if (reg_addr == `EAL_REG_RATE) begin
                    reg_rate <= reg_wdata;
                end else if (reg_addr == `EAL_REG_MODE) begin
                    reg_mode <= reg_wdata;
                end else if (reg_addr == `EAL_REG_REFMODE) begin
                    reg_refmode <= reg_wdata;
                end else if (reg_addr == `EAL_REG_MON) begin
                    reg_mon <= reg_wdata;
                end else if (reg_addr == `EAL_REG_THR) begin
                    reg_thr <= reg_wdata;
                end else if (reg_addr == `EAL_REG_WA) begin
                    reg_wa <= reg_wdata;
                end else if (reg_addr == `EAL_REG_OB) begin
                    reg_ob <= reg_wdata;
                end else if (reg_addr == `EAL_REG_OC) begin
                    reg_oc <= reg_wdata;
                end else if (reg_addr == `EAL_REG_FOMEN) begin
                    reg_fomen <= reg_wdata;
                end
            end
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        if (reg_addr == `EAL_REG_BOOST) begin
            next_rdata = reg_boost;
        end else if (reg_addr == `EAL_REG_LOOK) begin
            next_rdata = reg_look;
        end else if (reg_addr == `EAL_REG_RATE) begin
            next_rdata = reg_rate;
        end else if (reg_addr == `EAL_REG_MODE) begin
            next_rdata = reg_mode;
        end else if (reg_addr == `EAL_REG_REFMODE) begin
            next_rdata = reg_refmode;
        end else if (reg_addr == `EAL_REG_MON) begin
            next_rdata = reg_mon;
        end else if (reg_addr == `EAL_REG_THR) begin
            next_rdata = reg_thr;
        end else if (reg_addr == `EAL_REG_WA) begin
            next_rdata = reg_wa;
        end else if (reg_addr == `EAL_REG_OB) begin
            next_rdata = reg_ob;
        end else if (reg_addr == `EAL_REG_OC) begin
            next_rdata = reg_oc;
        end else if (reg_addr == `EAL_REG_FOMEN) begin
            next_rdata = reg_fomen;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata     <= 8'h00;
            start_prev    <= 1'b0;
            cdr_rate_code <= 4'h0;
        end else begin
            reg_rdata     <= next_rdata;
            start_prev    <= reg_rate[`EAL_START_BIT];
            cdr_rate_code <= reg_rate[`EAL_RATE_HI:`EAL_SUB_LO]; // see R7
        end
    end

    // Acquisition, adaptation and lock sequencing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state        <= S_CAL;
            cur_idx      <= 5'h00;
            best_idx     <= 5'h00;
            best_score   <= 10'h000;
            cur_score    <= 10'h000;
            beyond       <= 4'h0;
            timer        <= 13'h0000;
            mon_pend     <= 1'b0;
            boost_wr_hw  <= 1'b0;
            eye_meas_req <= 1'b0;
            lol_irq      <= 1'b0;
        end else begin
            boost_wr_hw  <= 1'b0;
            eye_meas_req <= 1'b0;
            lol_irq      <= unlock;                                // see R17
            timer        <= timer + 13'h0001;
            if ((start_evt || unlock) && state != S_CAL) begin   // see R12, R13
                state      <= S_ACQ;                               // see R18
                cur_idx    <= 5'h00;
                best_idx   <= 5'h00;
                best_score <= 10'h000;
                beyond     <= 4'h0;
                timer      <= 13'h0000;
                mon_pend   <= 1'b0;
            end else begin
                case (state)
                    S_CAL: begin
                        timer <= 13'h0000;
                        if (cal_done) begin                        // see R16
                            state <= S_ACQ;
                        end
                    end
                    S_ACQ: begin
                        timer <= 13'h0000;
                        state <= adapt_on ? S_STEP : S_CHECK;       // see R12
                    end
                    S_STEP: begin
                        if (cdr_phase_locked) begin
                            eye_meas_req <= 1'b1;                  // see R1
                            timer        <= 13'h0000;
                            state        <= S_MEAS;
                        end else if (timer == `EAL_LOCK_WAIT_CYC) begin
                            cur_score <= 10'h000;
                            state     <= S_EVAL;
                        end
                    end
                    S_MEAS: begin
                        if (eye_meas_done) begin
                            cur_score <= score;                    // see R1
                            state     <= S_EVAL;
                        end else if (timer == `EAL_MEAS_WAIT_CYC) begin
                            cur_score <= 10'h000;
                            state     <= S_EVAL;
                        end
                    end
                    S_EVAL: begin
                        timer <= 13'h0000;
                        if (cur_score > best_score) begin          // see R19
                            best_score <= cur_score;
                            best_idx   <= cur_idx;
                            beyond     <= 4'h0;
                        end else begin
                            beyond <= beyond + 4'h1;
                        end
                        if ((cur_score <= best_score
                             && beyond == reg_look[`EAL_LOOK_HI:0])
                            || cur_idx == `EAL_LAST_IDX) begin
                            if (cur_score > best_score) begin
                                best_idx <= cur_idx;
                            end
                            cur_idx     <= (cur_score > best_score) ?
                                           cur_idx : best_idx;     // see R19
                            boost_wr_hw <= 1'b1;                   // see R20
                            state       <= S_CHECK;
                        end else begin
                            cur_idx <= cur_idx + 5'h01;
                            state   <= S_STEP;
                        end
                    end
                    S_CHECK: begin
                        if (cdr_phase_locked) begin
                            eye_meas_req <= 1'b1;
                            timer        <= 13'h0000;
                            state        <= S_VERIFY;
                        end else if (timer == `EAL_LOCK_WAIT_CYC) begin
                            state <= S_ACQ;
                        end
                    end
                    S_VERIFY: begin
                        if (eye_meas_done) begin
                            state <= eye_ok ? S_LOCKED : S_ACQ;    // see R9
                            timer <= 13'h0000;
                        end else if (timer == `EAL_MEAS_WAIT_CYC) begin
                            state <= S_ACQ;
                        end
                    end
                    S_LOCKED: begin
                        if (mon_pend) begin
                            if (eye_meas_done ||
                                timer == `EAL_MEAS_WAIT_CYC) begin
                                mon_pend <= 1'b0;
                                timer    <= 13'h0000;
                            end
                        end else if (!reg_mon[`EAL_MON_EN_BIT]) begin
                            timer <= 13'h0000;                     // see R11
                        end else if (timer == `EAL_MON_GAP_CYC) begin
                            eye_meas_req <= 1'b1;                  // see R10
                            mon_pend     <= 1'b1;
                            timer        <= 13'h0000;
                        end
                    end
                    default: state <= S_CAL;
                endcase
            end
        end
    end

    // Equalizer drive and status outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            eq_boost_idx <= 5'h00;
            cdr_acquire  <= 1'b0;
            lock_status  <= 1'b0;
            adapt_busy   <= 1'b0;
        end else begin
            eq_boost_idx <= adapt_on ? cur_idx : reg_boost[4:0];  // see R8
            cdr_acquire  <= (state != S_CAL) && (state != S_LOCKED);
            lock_status  <= (state == S_LOCKED) && !unlock;
            adapt_busy   <= (state == S_STEP) || (state == S_MEAS)
                            || (state == S_EVAL);
        end
    end

endmodule // eal_top

/* File: eal_params.svh */
// Offsets, field positions, reset values and timing counts
// Overview of operation
// R1 - Measure both eye openings at every candidate
// R2 - Default score: min of horizontal, scaled vertical
// R3 - Score type field picks both, horizontal, vertical
// R4 - Custom score: (h-b)*a plus (v-c)*(1-a)
// R5 - Factors a, b, c from three registers
// R6 - Custom score used only while enable set
// R7 - Rate and subrate form four-bit search code
// R8 - Mode field: 00 no adapt, 01 adapt
// R9 - Lock only when both openings exceed minimums
// R10 - While locked, drop below minimum loses lock
// R11 - Clearing monitor enable stops lock monitoring
// R12 - On unlock reacquire, and readapt if enabled
// R13 - Software start bit one then zero starts
// R14 - Software sets reference mode field to three
// R15 - System supplies continuous reference clock
// R16 - Reset calibrates coarse oscillator from reference
// R17 - Reference detects drift, raises loss interrupt
// R18 - Spur lock detected restarts adaptation and lock
// R19 - Step while improving, look beyond, restore best
// R20 - Chosen boost written back to boost register
// R21 - Reserved mode codes behave as no adaptation
// R22 - Rate code meaning from implementation table
`ifndef EAL_PARAMS_SVH
`define EAL_PARAMS_SVH

`define EAL_REG_BOOST      8'h03
`define EAL_REG_LOOK       8'h2c
`define EAL_REG_RATE       8'h2f
`define EAL_REG_MODE       8'h31
`define EAL_REG_REFMODE    8'h36
`define EAL_REG_MON        8'h3e
`define EAL_REG_THR        8'h6a
`define EAL_REG_WA         8'h6b
`define EAL_REG_OB         8'h6c
`define EAL_REG_OC         8'h6d
`define EAL_REG_FOMEN      8'h6e

`define EAL_RST_BOOST      8'h00
`define EAL_RST_LOOK       8'h02
`define EAL_RST_RATE       8'h00
`define EAL_RST_MODE       8'h20
`define EAL_RST_REFMODE    8'h30
`define EAL_RST_MON        8'h80
`define EAL_RST_THR        8'h44
`define EAL_RST_WA         8'h80
`define EAL_RST_OB         8'h00
`define EAL_RST_OC         8'h00
`define EAL_RST_FOMEN      8'h00

`define EAL_START_BIT      0
`define EAL_RATE_HI        7
`define EAL_SUB_LO         4
`define EAL_MODE_HI        6
`define EAL_MODE_LO        5
`define EAL_TYPE_HI        4
`define EAL_TYPE_LO        3
`define EAL_LOOK_HI        3
`define EAL_MON_EN_BIT     7
`define EAL_FOM_EN_BIT     7
`define EAL_MODE_ADAPT     2'b01

`define EAL_LAST_IDX       5'h1f
`define EAL_LAST_COARSE    4'hf
`define EAL_VEO_SCALE      8'h50
`define EAL_REF_WIN        6'h3f
`define EAL_DRIFT_TOL      12'h040
`define EAL_SPUR_TOL       12'h008

`define EAL_CLK_NS         50
`define EAL_LOCK_WAIT_NS   20000
`define EAL_MEAS_WAIT_NS   100000
`define EAL_MON_GAP_NS     10000
`define EAL_LOCK_WAIT_CYC  ((`EAL_LOCK_WAIT_NS + `EAL_CLK_NS - 1) / `EAL_CLK_NS)
`define EAL_MEAS_WAIT_CYC  ((`EAL_MEAS_WAIT_NS + `EAL_CLK_NS - 1) / `EAL_CLK_NS)
`define EAL_MON_GAP_CYC    ((`EAL_MON_GAP_NS + `EAL_CLK_NS - 1) / `EAL_CLK_NS)

`endif

/* File: eal_pkg.sv */
// Types and shared functions of the adaptation and lock control
package eal_pkg;

    typedef enum logic [7:0] {
        S_CAL    = 8'h01,
        S_ACQ    = 8'h02,
        S_STEP   = 8'h04,
        S_MEAS   = 8'h08,
        S_EVAL   = 8'h10,
        S_CHECK  = 8'h20,
        S_VERIFY = 8'h40,
        S_LOCKED = 8'h80
    } eal_state_t;

    typedef struct packed {
        logic [7:0] horizontal_eye_width;
        logic [7:0] vertical_eye_height;
    } eal_eye_t;

    typedef struct packed {
        logic [1:0] fom_type;
        logic       custom_en;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } eal_fom_cfg_t;

    // Expected oscillator ticks per reference window for a rate code
    function automatic logic [11:0] eal_expected(input logic [3:0] code);
        logic [11:0] base;
        base = 12'h000;
        case (code[3:2])
            2'b00:   base = 12'h550;
            2'b01:   base = 12'h620;
            2'b10:   base = 12'h670;
            default: base = 12'h710;
        endcase
        return base >> code[1:0];
    endfunction

    function automatic logic [11:0] eal_absdiff(input logic [11:0] x,
                                                input logic [11:0] y);
        return (x > y) ? (x - y) : (y - x);
    endfunction

endpackage

/* File: eal_score.sv */
// Eye quality score of one boost setting
`timescale 1ns/1ns
`include "eal_params.svh"
module eal_score (
    // Eye measurement and scoring setup
    input  wire eal_pkg::eal_eye_t     eye,
    input  wire eal_pkg::eal_fom_cfg_t cfg,
    // Score
    output logic [9:0]                 score
);
    import eal_pkg::*;

    logic        [15:0] veo_prod;
    logic        [9:0]  h_s;
    logic        [9:0]  v_s;
    logic signed [9:0]  dh;
    logic signed [9:0]  dv;
    logic signed [9:0]  wa;
    logic signed [9:0]  wb;
    logic signed [20:0] acc;

    always_comb begin
        veo_prod = eye.vertical_eye_height * `EAL_VEO_SCALE;
        h_s      = {2'h0, eye.horizontal_eye_width};
        v_s      = veo_prod[15:6];                          // see R2
        dh       = $signed({2'h0, eye.horizontal_eye_width}) - $signed({2'h0, cfg.b});
        dv       = $signed({2'h0, eye.vertical_eye_height}) - $signed({2'h0, cfg.c});
        wa       = $signed({2'h0, cfg.a});                  // see R5
        wb       = $signed(10'h100) - wa;
        acc      = 21'(dh * wa) + 21'(dv * wb);             // see R4
        if (cfg.custom_en) begin                            // see R6
            if (acc < 0) begin
                score = 10'h000;
            end else if (acc[20:18] != 3'h0) begin
                score = 10'h3ff;
            end else begin
                score = acc[17:8];
            end
        end else begin
            case (cfg.fom_type)                             // see R3
                2'b01:   score = h_s;
                2'b10:   score = v_s;
                default: score = (h_s < v_s) ? h_s : v_s;   // see R2
            endcase
        end
    end

endmodule // eal_score

/* File: eal_refmon.sv */
// Reference clock comparison: coarse calibration, drift and spur checks
`timescale 1ns/1ns
`include "eal_params.svh"
module eal_refmon (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Tick inputs
    input  wire logic       ref_tick,
    input  wire logic       vco_tick,
    // Control
    input  wire logic [3:0] rate_code,
    input  wire logic       locked,
    // Results
    output logic [3:0]      coarse_sel,
    output logic            cal_done,
    output logic            drift_evt,
    output logic            spur_evt
);
    import eal_pkg::*;

    logic [5:0]  win_cnt;
    logic [11:0] vco_cnt;
    logic [11:0] diff;
    logic [11:0] best_diff;
    logic [3:0]  best_sel;
    logic        win_end;

    assign win_end = ref_tick && (win_cnt == `EAL_REF_WIN);
    assign diff    = eal_absdiff(vco_cnt, eal_expected(rate_code)); // see R22

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            win_cnt <= 6'h00;
            vco_cnt <= 12'h000;
        end else begin
            if (ref_tick) begin
                win_cnt <= win_end ? 6'h00 : win_cnt + 6'h01;
            end
            if (win_end) begin
                vco_cnt <= 12'h000;
            end else if (vco_tick && vco_cnt != 12'hfff) begin
                vco_cnt <= vco_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            coarse_sel <= 4'h0;
            best_sel   <= 4'h0;
            best_diff  <= 12'hfff;
            cal_done   <= 1'b0;
        end else if (win_end && !cal_done) begin           // see R16
            if (diff < best_diff) begin
                best_diff <= diff;
                best_sel  <= coarse_sel;
            end
            if (coarse_sel == `EAL_LAST_COARSE) begin
                coarse_sel <= (diff < best_diff) ? coarse_sel : best_sel;
                cal_done   <= 1'b1;
            end else begin
                coarse_sel <= coarse_sel + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drift_evt <= 1'b0;
            spur_evt  <= 1'b0;
        end else begin
            drift_evt <= win_end && locked && (diff > `EAL_DRIFT_TOL); // see R17
            spur_evt  <= win_end && locked && (diff > `EAL_SPUR_TOL)
                         && (diff <= `EAL_DRIFT_TOL);                 // see R18
        end
    end

endmodule // eal_refmon

/* File: eal_chk.sv */
// Port assertions of the adaptation and lock control
`timescale 1ns/1ns
module eal_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Watched ports
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] cdr_rate_code,
    input wire logic       cdr_acquire,
    input wire logic       eye_meas_req,
    input wire logic       lock_status,
    input wire logic       adapt_busy,
    input wire logic       lol_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_rate_code: assert property (reg_wr && reg_addr == 8'h2f
        |-> ##2 cdr_rate_code == $past(reg_wdata[7:4], 2)) else $error("rate");
    chk_read_back: assert property ((reg_wr && reg_addr == 8'h6b)
        ##1 (!reg_wr && reg_addr == 8'h6b) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback");
    chk_lock_cause: assert property ($rose(lock_status)
        |-> $past(cdr_acquire)) else $error("lock");
    chk_lol_pulse: assert property (lol_irq |=> !lol_irq)
        else $error("irq width");
    chk_lol_cause: assert property (lol_irq
        |-> $past(lock_status) || $past(lock_status, 2)) else $error("irq");
    chk_lol_restart: assert property (lol_irq
        |-> ##[1:4] cdr_acquire) else $error("restart");
    chk_req_pulse: assert property (eye_meas_req
        |=> !eye_meas_req) else $error("req");
    chk_busy_unlocked: assert property (adapt_busy
        |-> !lock_status) else $error("busy");
    cover property ($rose(lock_status));
    cover property (lol_irq);
    cover property ($rose(adapt_busy));
endmodule // eal_chk

bind eal_top eal_chk i_chk (.*);

/* File: eal_chan.sv */
// Far side model: eye scanner, phase lock and tick sources
`timescale 1ns/1ns
module eal_chan (
    // Clock
    input wire logic         sys_clk,
    // Design side
    input wire logic         eye_meas_req,
    input wire logic [4:0]   eq_boost_idx,
    output logic             eye_meas_done,
    output eal_pkg::eal_eye_t eye_meas,
    output logic             cdr_phase_locked,
    output logic             ref_tick,
    output logic             vco_tick,
    // Scenario controls
    input wire logic [7:0]   lat,
    input wire logic         eye_bad,
    input wire logic         vco_on
);
    import eal_pkg::*;
    logic [7:0] wcnt = 8'h00;
    logic [4:0] rcnt = 5'h00;
    logic [5:0] tk   = 6'h00;
    logic       busy = 1'b0;
    // Eye falls by 16 per step away from its peak
    function automatic logic [7:0] eo(input logic [4:0] pk);
        logic [4:0] d;
        d = (eq_boost_idx > pk) ? eq_boost_idx - pk : pk - eq_boost_idx;
        return eye_bad ? 8'h20 : 8'hc0 - {d[3:0], 4'h0};
    endfunction
    initial eye_meas = 16'h0000;
    assign cdr_phase_locked = vco_on;
    always @(posedge sys_clk) begin
        eye_meas_done <= busy && wcnt == 8'h00;
        eye_meas <= (busy && wcnt == 8'h00) ? {eo(5'h03), eo(5'h06)} : ~eye_meas;
        busy <= eye_meas_req || (busy && wcnt != 8'h00);
        wcnt <= eye_meas_req ? lat : wcnt - {7'h00, wcnt != 8'h00};
    end
    // 64 reference periods hold 1360 oscillator ticks
    always @(posedge sys_clk) begin
        vco_tick <= vco_on;
        ref_tick <= rcnt == 5'h00;
        tk <= tk + {5'h00, rcnt == 5'h00};
        if (rcnt == 5'h00) begin
            rcnt <= (tk[1:0] == 2'b00) ? 5'h15 : 5'h14;
        end else begin
            rcnt <= rcnt - 5'h01;
        end
    end
endmodule // eal_chan

/* File: tb_eal_top.sv */
// Testbench of the adaptation and lock control
`timescale 1ns/1ns
module tb_eal_top;
    import eal_pkg::*;
    logic       sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0;
    logic       eye_bad = 1'b0, vco_on = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lat = 8'h05, v;
    logic [7:0] reg_rdata;
    logic [3:0] cdr_rate_code, coarse_vco_sel;
    logic [4:0] eq_boost_idx;
    logic       cdr_acquire, cdr_phase_locked, eye_meas_req, eye_meas_done;
    logic       ref_tick, vco_tick, lock_status, adapt_busy, lol_irq;
    eal_eye_t   eye_meas;
    int         n_errors = 0, total_checks = 0;
    always #25 sys_clk = ~sys_clk;
    eal_top i_dut (.*);
    eal_chan i_chan (.*);
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        cyc(2);
        v = reg_rdata;
    endtask
    task automatic wl(input logic s);
        for (int i = 0; i < 60000 && lock_status !== s; i++) cyc(1);
        chk({7'h00, lock_status}, {7'h00, s});
        if (lock_status !== s) results();
    endtask
    logic [7:0] ra[7] = '{8'h2c, 8'h31, 8'h36, 8'h3e, 8'h6a, 8'h6b, 8'h7f};
    logic [7:0] rv[7] = '{8'h02, 8'h20, 8'h30, 8'h80, 8'h44, 8'h80, 8'h00};
    logic [7:0] am[5] = '{8'h20, 8'h28, 8'h30, 8'h38, 8'h20};
    logic [7:0] ae[5] = '{8'h03, 8'h03, 8'h06, 8'h03, 8'h06};
    initial begin
        cyc(5);
        rst_n = 1'b1;
        for (int k = 0; k < 7; k++) begin
            rd(ra[k]);
            chk(v, rv[k]);
        end
        wl(1'b1);
        chk({3'h0, eq_boost_idx}, 8'h03);
        $display("reset test done");
        wr(8'h6b, 8'h00);
        rd(8'h6b);
        chk(v, 8'h00);
        for (int k = 0; k < 5; k++) begin
            lat = 8'(k * 40);
            wr(8'h31, am[k]);
            wr(8'h6e, (k == 4) ? 8'h80 : 8'h00);
            wr(8'h2f, 8'h01);
            wr(8'h2f, 8'h00);
            wl(1'b0);
            wl(1'b1);
            chk({3'h0, eq_boost_idx}, ae[k]);
            rd(8'h03);
            chk(v, ae[k]);
        end
        $display("scoring done");
        eye_bad = 1'b1;
        wl(1'b0);
        eye_bad = 1'b0;
        wl(1'b1);
        wr(8'h3e, 8'h00);
        eye_bad = 1'b1;
        cyc(1000);
        chk({7'h00, lock_status}, 8'h01);
        eye_bad = 1'b0;
        wr(8'h3e, 8'h80);
        vco_on = 1'b0;
        wl(1'b0);
        vco_on = 1'b1;
        wl(1'b1);
        $display("lock loss done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h31, k[0] ? 8'h60 : 8'h00);
            wr(8'h03, 8'(10 + k));
            cyc(4);
            chk({3'h0, eq_boost_idx}, 8'(10 + k));
        end
        wr(8'h2f, 8'hd0);
        cyc(3);
        chk({4'h0, cdr_rate_code}, 8'h0d);
        wl(1'b0);
        $display("mode and rate done");
        results();
    end
endmodule // tb_eal_top
